// file: trc_osc_ctrl.sv
// Control and status for two tone oscillators and a ringing oscillator.
// Assumes a classic Wishbone master, 100 MHz mclk_in and a synchronous reset.
//
// Overview of operation
// [R01] Tone one status reads output activity
// [R02] Tone one reload repeats, else stops
// [R03] Software sets reload for FSK signalling
// [R04] Tone one zero-cross chooses burst end
// [R05] Tone one timers run only when enabled
// [R06] Tone outputs only while enable bit set
// [R07] Tone one route: none, tx, rx, both
// [R08] Tone two status reads output activity
// [R09] Tone two zero-cross chooses signal end
// [R10] Tone two timers run only when enabled
// [R11] Tone two route same; bit six zero
// [R12] Ringing status reads output activity
// [R13] Ringing held until dc continuity; line flag
// [R14] Ringing timers run only when enabled
// [R15] Ringing running flag reads enable state
// [R16] Offset bit adds dc offset
// [R17] Wave select: sinusoid or trapezoid
// [R18] Timers are 16-bit, 125 us counts
// [R19] Active and inactive periods alternate
// [R20] Reserved bits read zero; reset clears
`timescale 1ns/10ps
module trc_osc_ctrl
  import trc_pkg::*;
#(
  parameter int TICK_CYCLES = TRC_TICK_CYC
)
(
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        ring_mode_in,
  input  wire logic [2:0]  zero_cross_in,
  input  wire logic        ring_dc_cross_in,
  output logic             tone1_tx_out,
  output logic             tone1_rx_out,
  output logic             tone2_tx_out,
  output logic             tone2_rx_out,
  output logic             ring_drive_out,
  output logic             ring_dc_offset_out,
  output logic             ring_wave_select_out
);

  // ==========================================================================
  // Declarations
  logic [7:0]   tone1_control_reg;
  logic [7:0]   tone2_control_reg;
  logic [7:0]   ringing_control_reg;
  logic [15:0]  period_reg [TRC_N_TIMER];
  logic         ack_reg;
  logic [31:0]  rdata_reg;
  logic [15:0]  tick_cnt_reg;
  logic         tick_reg;
  logic         ring_on_line_reg;
  logic         ring_running_reg;
  logic [3:0]   path_reg;
  logic [1:0]   shape_reg;
  logic         req;
  logic         wr;
  logic [5:0]   idx;
  logic [TRC_N_OSC-1:0] osc_act;
  trc_cad_cfg_t cfg [TRC_N_OSC];
  logic [7:0]   ctrl [TRC_N_OSC];
  logic [TRC_N_OSC-1:0] reload_en;

  // Index of a timer word, valid only when timer_hit is true
  function automatic logic timer_hit(input logic [5:0] i);
    return (i >= TRC_IDX_TIMER_BASE) && (i <= TRC_IDX_TIMER_LAST);
  endfunction

  function automatic logic [2:0] timer_sel(input logic [5:0] i);
    logic [5:0] d;
    d = i - TRC_IDX_TIMER_BASE;
    return d[2:0];
  endfunction

  // ==========================================================================
  // Wishbone request decode
  assign req = wb_cyc_in && wb_stb_in && !ack_reg;
  // Writes land at the edge where the master samples ack high
  assign wr  = wb_cyc_in && wb_stb_in && wb_we_in && ack_reg;
  assign idx = wb_adr_in[7:2];

  // Acknowledge one cycle after the request; dropped the cycle after
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  assign wb_ack_out = ack_reg;

  // ==========================================================================
  // Control registers; only writable bits are stored
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tone1_control_reg <= TRC_CTRL_RST;                           // [R20]
    end else if (wr && wb_sel_in[0] && idx == TRC_IDX_TONE1) begin
      tone1_control_reg <= wb_dat_in[7:0] & TRC_MASK_TONE1;        // [R20]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tone2_control_reg <= TRC_CTRL_RST;                           // [R20]
    end else if (wr && wb_sel_in[0] && idx == TRC_IDX_TONE2) begin
      tone2_control_reg <= wb_dat_in[7:0] & TRC_MASK_TONE2;        // [R11]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ringing_control_reg <= TRC_CTRL_RST;                         // [R20]
    end else if (wr && wb_sel_in[0] && idx == TRC_IDX_RING) begin
      ringing_control_reg <= wb_dat_in[7:0] & TRC_MASK_RING;       // [R20]
    end
  end

  // Cadence period words, low and high byte lanes
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      for (int k = 0; k < TRC_N_TIMER; k++) begin
        period_reg[k] <= TRC_TIMER_RST;
      end
    end else if (wr && timer_hit(idx)) begin
      if (wb_sel_in[0]) begin
        period_reg[timer_sel(idx)][7:0] <= wb_dat_in[7:0];        // [R18]
      end
      if (wb_sel_in[1]) begin
        period_reg[timer_sel(idx)][15:8] <= wb_dat_in[15:8];      // [R18]
      end
    end
  end

  // ==========================================================================
  // Read-back views with live status bits
  always_comb begin
    ctrl[0] = tone1_control_reg;
    ctrl[0][TRC_B_STATUS] = osc_act[0];                            // [R01]
    ctrl[1] = tone2_control_reg;
    ctrl[1][TRC_B_STATUS] = osc_act[1];                            // [R08]
    ctrl[1][TRC_B_RELOAD] = 1'b0;                                  // [R11]
    ctrl[2] = ringing_control_reg;
    ctrl[2][TRC_B_STATUS] = osc_act[2];                            // [R12]
    ctrl[2][TRC_B_R_LINE] = ring_on_line_reg;                      // [R13]
    ctrl[2][TRC_B_RUN]    = ring_running_reg;                      // [R15]
  end

  // Read data captured with the acknowledge; unmapped reads give zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (req) begin
      if (idx == TRC_IDX_TONE1) begin
        rdata_reg <= {24'h00_0000, ctrl[0]};
      end else if (idx == TRC_IDX_TONE2) begin
        rdata_reg <= {24'h00_0000, ctrl[1]};
      end else if (idx == TRC_IDX_RING) begin
        rdata_reg <= {24'h00_0000, ctrl[2]};
      end else if (timer_hit(idx)) begin
        rdata_reg <= {16'h0000, period_reg[timer_sel(idx)]};
      end else begin
        rdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign wb_dat_out = rdata_reg;

  // ==========================================================================
  // Cadence tick, one pulse per count
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg     <= 1'b1;                                        // [R18]
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg     <= 1'b0;
    end
  end

  // ==========================================================================
  // Sequencer configuration; ringing runs while the line is in ringing mode
  assign reload_en[0] = tone1_control_reg[TRC_B_RELOAD];           // [R02]
  assign reload_en[1] = 1'b1;
  assign reload_en[2] = 1'b1;

  genvar g;
  generate
    for (g = 0; g < TRC_N_OSC; g++) begin : g_osc
      always_comb begin
        cfg[g].run        = (g == 2) ? ring_mode_in : ctrl[g][TRC_B_RUN];  // [R06]
        cfg[g].on_en      = ctrl[g][TRC_B_ON_EN];
        cfg[g].off_en     = ctrl[g][TRC_B_OFF_EN];
        cfg[g].reload     = reload_en[g];
        cfg[g].zc_en      = (g == 2) ? 1'b0 : ctrl[g][TRC_B_ZC];
        cfg[g].on_period  = period_reg[2 * g];
        cfg[g].off_period = period_reg[2 * g + 1];
      end

      trc_cadence u_cad (
        .mclk_in       (mclk_in),
        .reset_in      (reset_in),
        .tick_in       (tick_reg),
        .zero_cross_in (zero_cross_in[g]),
        .cfg_in        (cfg[g]),
        .active_out    (osc_act[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Ringing enable flag follows the linefeed ringing mode
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ring_running_reg <= 1'b0;
    end else begin
      ring_running_reg <= ring_mode_in;                            // [R15]
    end
  end

  // Line drive changes only at a dc linefeed crossing
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ring_on_line_reg <= 1'b0;
    end else if (ring_dc_cross_in) begin
      ring_on_line_reg <= osc_act[2];                              // [R13]
    end
  end

  assign ring_drive_out = ring_on_line_reg;

  // ==========================================================================
  // Path routing of the tone outputs
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      path_reg <= 4'h0;
    end else begin
      path_reg[0] <= osc_act[0] && tone1_control_reg[TRC_B_RT_TX];  // [R07]
      path_reg[1] <= osc_act[0] && tone1_control_reg[TRC_B_RT_RX];  // [R07]
      path_reg[2] <= osc_act[1] && tone2_control_reg[TRC_B_RT_TX];  // [R11]
      path_reg[3] <= osc_act[1] && tone2_control_reg[TRC_B_RT_RX];  // [R11]
    end
  end

  assign tone1_tx_out = path_reg[0];
  assign tone1_rx_out = path_reg[1];
  assign tone2_tx_out = path_reg[2];
  assign tone2_rx_out = path_reg[3];

  // Ringing offset and waveshape selection
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      shape_reg <= 2'h0;
    end else begin
      shape_reg[0] <= ringing_control_reg[TRC_B_R_OFS];            // [R16]
      shape_reg[1] <= ringing_control_reg[TRC_B_R_WAVE];           // [R17]
    end
  end

  assign ring_dc_offset_out   = shape_reg[0];
  assign ring_wave_select_out = shape_reg[1];

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  // Read request as taken, and write as it lands
  sequence seq_rd(logic [5:0] at);
    req && !wb_we_in && idx == at;
  endsequence

  sequence seq_wr(logic [5:0] at);
    wr && wb_sel_in[0] && idx == at;
  endsequence

  tone1_flag_a: assert property (seq_rd(TRC_IDX_TONE1)                  // [R01]
    |=> wb_ack_out && wb_dat_out[TRC_B_STATUS] == $past(osc_act[0]))
    else $error("tone one status wrong");
  tone2_flag_a: assert property (seq_rd(TRC_IDX_TONE2)                  // [R08]
    |=> wb_dat_out[TRC_B_STATUS] == $past(osc_act[1]) && wb_dat_out[TRC_B_RELOAD] == 1'b0)
    else $error("tone two status wrong");
  ring_flag_a: assert property (seq_rd(TRC_IDX_RING)                    // [R12]
    |=> wb_dat_out[TRC_B_STATUS] == $past(osc_act[2]) && wb_dat_out[31:8] == 24'h00_0000)
    else $error("ringing status wrong");
  reserved_zero_a: assert property (seq_rd(TRC_IDX_RING)                // [R20]
    |=> wb_dat_out[TRC_B_RELOAD] == 1'b0) else $error("reserved bit set");
  tone_route_a: assert property (1'b1                                   // [R07]
    |=> tone1_tx_out == $past(osc_act[0] && tone1_control_reg[TRC_B_RT_TX]))
    else $error("tone one routing wrong");
  tone1_rx_a: assert property (1'b1                                     // [R07]
    |=> tone1_rx_out == $past(osc_act[0] && tone1_control_reg[TRC_B_RT_RX]))
    else $error("tone one receive routing wrong");
  tone2_route_a: assert property ((tone2_tx_out || tone2_rx_out)        // [R11]
    |-> $past(osc_act[1])) else $error("tone two routed while inactive");
  tone1_off_a: assert property (!tone1_control_reg[TRC_B_RUN]           // [R06]
    [*3] |=> !tone1_tx_out && !tone1_rx_out) else $error("tone one active while off");
  tone_off_a: assert property (!tone2_control_reg[TRC_B_RUN]            // [R06]
    [*3] |=> !tone2_tx_out && !tone2_rx_out) else $error("tone two active while off");
  ring_hold_a: assert property ((!ring_on_line_reg && !ring_dc_cross_in) // [R13]
    |=> !ring_drive_out) else $error("ringing left dc feed early");
  ring_shape_a: assert property (1'b1                                   // [R16]
    |=> ring_dc_offset_out == $past(ringing_control_reg[TRC_B_R_OFS]))
    else $error("offset not applied");
  ring_wave_a: assert property (1'b1                                    // [R17]
    |=> ring_wave_select_out == $past(ringing_control_reg[TRC_B_R_WAVE]))
    else $error("waveshape not applied");
  ack_once_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");

  // Handshake, line flag, running flag, write mask and tick shape
  ack_next_a: assert property (req |=> wb_ack_out)
    else $error("request not acknowledged");
  line_flag_a: assert property (ring_dc_cross_in                        // [R13]
    |=> ring_on_line_reg == $past(osc_act[2])) else $error("line flag missed a crossing");
  run_flag_a: assert property (seq_rd(TRC_IDX_RING)                     // [R15]
    |=> wb_dat_out[TRC_B_RUN] == $past(ring_running_reg)) else $error("running flag not read back");
  tone2_mask_a: assert property (seq_wr(TRC_IDX_TONE2)                  // [R20]
    |=> tone2_control_reg[TRC_B_STATUS] == 1'b0 && tone2_control_reg[TRC_B_RELOAD] == 1'b0)
    else $error("reserved tone two bits stored");
  tick_gap_a: assert property (tick_reg |=> !tick_reg)                  // [R18]
    else $error("cadence tick longer than one cycle");

endmodule // trc_osc_ctrl

// file: trc_pkg.sv
// Constants and types shared by the tone and ringing oscillator control logic.
// Assumes a 100 MHz system clock and a word-aligned classic Wishbone slave port.
package trc_pkg;

  // ==========================================================================
  // Timing
  localparam int TRC_CLK_NS   = 10;                         // System clock period
  localparam int TRC_TICK_NS  = 125000;                     // One cadence count
  localparam int TRC_TICK_CYC = TRC_TICK_NS / TRC_CLK_NS;   // Cycles per count

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] TRC_IDX_TONE1      = 6'h20;
  localparam logic [5:0] TRC_IDX_TONE2      = 6'h21;
  localparam logic [5:0] TRC_IDX_RING       = 6'h22;
  localparam logic [5:0] TRC_IDX_TIMER_BASE = 6'h24;
  localparam logic [5:0] TRC_IDX_TIMER_LAST = 6'h29;
  localparam int         TRC_N_OSC          = 3;
  localparam int         TRC_N_TIMER        = 6;

  // ==========================================================================
  // Control field positions
  localparam int TRC_B_STATUS  = 7;
  localparam int TRC_B_RELOAD  = 6;
  localparam int TRC_B_ZC      = 5;
  localparam int TRC_B_ON_EN   = 4;
  localparam int TRC_B_OFF_EN  = 3;
  localparam int TRC_B_RUN     = 2;
  localparam int TRC_B_RT_TX   = 0;
  localparam int TRC_B_RT_RX   = 1;
  localparam int TRC_B_R_LINE  = 5;
  localparam int TRC_B_R_OFS   = 1;
  localparam int TRC_B_R_WAVE  = 0;

  // ==========================================================================
  // Writable masks and reset values
  localparam logic [7:0]  TRC_MASK_TONE1 = 8'h7F;
  localparam logic [7:0]  TRC_MASK_TONE2 = 8'h3F;
  localparam logic [7:0]  TRC_MASK_RING  = 8'h1B;
  localparam logic [7:0]  TRC_CTRL_RST   = 8'h00;
  localparam logic [15:0] TRC_TIMER_RST  = 16'h0000;

  // Cadence sequencer configuration
  typedef struct packed {
    logic        run;
    logic        on_en;
    logic        off_en;
    logic        reload;
    logic        zc_en;
    logic [15:0] on_period;
    logic [15:0] off_period;
  } trc_cad_cfg_t;

  // Cadence sequencer states, one-hot
  typedef enum logic [4:0] {
    TRC_IDLE  = 5'h01,
    TRC_ON    = 5'h02,
    TRC_DRAIN = 5'h04,
    TRC_OFF   = 5'h08,
    TRC_DONE  = 5'h10
  } trc_cad_state_t;

endpackage

// file: trc_cadence.sv
// Active/inactive cadence sequencer for one oscillator.
// Assumes tick_in is a one-cycle pulse per cadence count.
`timescale 1ns/10ps
module trc_cadence
  import trc_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         reset_in,
  input  wire logic         tick_in,
  input  wire logic         zero_cross_in,
  input  wire trc_cad_cfg_t cfg_in,
  output logic              active_out
);

  trc_cad_state_t state_reg;
  logic [15:0]    cnt_reg;
  logic           on_exp;
  logic           off_exp;
  logic           restart;

  // ==========================================================================
  // Expiry; each timer counts only when enabled
  assign on_exp  = cfg_in.on_en && (cnt_reg == cfg_in.on_period);    // [R05] [R10] [R14]
  assign off_exp = cfg_in.off_en && (cnt_reg == cfg_in.off_period);  // [R05] [R10] [R14]

  // State sequencing
  always_ff @(posedge mclk_in) begin
    if (reset_in || !cfg_in.run) begin
      state_reg <= TRC_IDLE;                                       // [R06]
    end else begin
      case (state_reg)
        TRC_IDLE:  state_reg <= TRC_ON;
        TRC_ON: begin
          if (on_exp) begin
            state_reg <= cfg_in.zc_en ? TRC_DRAIN : TRC_OFF;      // [R04] [R09]
          end
        end
        TRC_DRAIN: begin
          if (zero_cross_in) begin
            state_reg <= TRC_OFF;                                  // [R04] [R09]
          end
        end
        TRC_OFF: begin
          if (off_exp) begin
            state_reg <= cfg_in.reload ? TRC_ON : TRC_DONE;       // [R02] [R19]
          end
        end
        TRC_DONE:  state_reg <= TRC_DONE;
        default:   state_reg <= TRC_IDLE;
      endcase
    end
  end

  // Counter restarts at every period boundary and outside the timed periods,
  // so no count left over from an earlier burst shortens the next one
  assign restart = (state_reg == TRC_IDLE) || (state_reg == TRC_DRAIN) || (state_reg == TRC_DONE) ||
                   (state_reg == TRC_ON && on_exp) || (state_reg == TRC_OFF && off_exp);

  // Count of ticks in the current period; only an enabled timer advances
  always_ff @(posedge mclk_in) begin
    if (reset_in || !cfg_in.run || restart) begin
      cnt_reg <= TRC_TIMER_RST;
    end else if (tick_in && ((state_reg == TRC_ON && cfg_in.on_en) ||
                             (state_reg == TRC_OFF && cfg_in.off_en))) begin
      cnt_reg <= cnt_reg + 16'h0001;                               // [R05] [R10] [R14]
    end
  end

  // Output forced on in the active and draining periods
  assign active_out = (state_reg == TRC_ON) || (state_reg == TRC_DRAIN);  // [R19]

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence seq_on_done;
    state_reg == TRC_ON && cfg_in.run && on_exp;
  endsequence

  sequence seq_off_done;
    state_reg == TRC_OFF && cfg_in.run && off_exp;
  endsequence

  on_hold_a: assert property ((state_reg == TRC_ON && cfg_in.run && !cfg_in.on_en)   // [R05]
    |=> state_reg == TRC_ON) else $error("active period left with timer off");
  direct_stop_a: assert property ((seq_on_done and !cfg_in.zc_en)                    // [R04]
    |=> state_reg == TRC_OFF && !active_out) else $error("burst not ended at expiry");
  zc_wait_a: assert property ((state_reg == TRC_DRAIN && cfg_in.run && !zero_cross_in) // [R04]
    |=> active_out) else $error("burst ended before zero crossing");
  reload_a: assert property ((seq_off_done and cfg_in.reload)                        // [R02]
    |=> active_out) else $error("reload did not restart");
  no_reload_a: assert property ((seq_off_done and !cfg_in.reload)                    // [R02]
    |=> !active_out [*2]) else $error("oscillator kept going without reload");

endmodule // trc_cadence

// file: test_tone_ring_osc_control.sv
// Self-checking bench for the tone and ringing oscillator control block.
// Assumes trc_pkg, trc_cadence and trc_osc_ctrl are compiled before this file.
`timescale 1ns/10ps
module test_tone_ring_osc_control;
  import trc_pkg::*;
  localparam int TK = 4;  // Cycles per cadence count in simulation
  logic        mclk_in, reset_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [7:0]  wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, q;
  logic        wb_ack_out, ring_mode_in, ring_dc_cross_in;
  logic [2:0]  zero_cross_in;
  logic        tone1_tx_out, tone1_rx_out, tone2_tx_out, tone2_rx_out;
  logic        ring_drive_out, ring_dc_offset_out, ring_wave_select_out;
  logic [7:0]  ctl [3] = '{8'h80, 8'h84, 8'h88};
  int          mismatches, n_checks, n;

  // ==========================================================================
  // Device under test
  trc_osc_ctrl #(.TICK_CYCLES(TK)) dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .ring_mode_in(ring_mode_in),
    .zero_cross_in(zero_cross_in), .ring_dc_cross_in(ring_dc_cross_in),
    .tone1_tx_out(tone1_tx_out), .tone1_rx_out(tone1_rx_out), .tone2_tx_out(tone2_tx_out),
    .tone2_rx_out(tone2_rx_out), .ring_drive_out(ring_drive_out),
    .ring_dc_offset_out(ring_dc_offset_out), .ring_wave_select_out(ring_wave_select_out));

  // ==========================================================================
  // Clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // ==========================================================================
  // Reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Wishbone single cycle; ack is read before the edge's own updates land
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d);
    int k = 0;
    @(posedge mclk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= adr;
    wb_sel_in <= sel;
    wb_dat_in <= d;
    do begin
      @(posedge mclk_in);
      k++;
    end while (wb_ack_out !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      wrap_up();
    end
    q = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 4'hF, 32'h0);
    check(q, exp);
  endtask

  // Tone activity as seen on the transmit route
  function automatic logic tone_on(input int i);
    return (i == 0) ? tone1_tx_out : tone2_tx_out;
  endfunction

  // Bounded wait for a tone level; n returns the cycles spent
  task automatic wait_lvl(input int i, input logic lvl, input int bound);
    n = 0;
    while (tone_on(i) !== lvl && n < bound) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= bound) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // Poll a ring control bit by reads until it takes a level
  task automatic poll_ring(input int b, input logic v);
    int k = 0;
    do begin
      wb(1'b0, 8'h88, 4'hF, 32'h0);
      k++;
    end while (q[b] !== v && k < 60);
    if (k >= 60) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    mismatches = 0;
    n_checks = 0;
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in} = '0;
    {ring_mode_in, zero_cross_in, ring_dc_cross_in} = '0;
    reset_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    // Reset values, reserved bits, unmapped place
    for (int i = 0; i < 3; i++) rd_chk(ctl[i], 32'h0);
    wb(1'b1, 8'hFC, 4'hF, 32'hFF);
    rd_chk(8'hFC, 32'h0);
    wb(1'b1, ctl[0], 4'h1, 32'hFB);
    wb(1'b1, ctl[1], 4'h1, 32'hFB);
    wb(1'b1, ctl[2], 4'h1, 32'hFF);
    rd_chk(ctl[0], 32'h7B);
    rd_chk(ctl[1], 32'h3B);
    rd_chk(ctl[2], 32'h1B);
    check({ring_dc_offset_out, ring_wave_select_out}, 2'b11);
    for (int i = 0; i < 3; i++) wb(1'b1, ctl[i], 4'h1, 32'h0);
    repeat (2) @(posedge mclk_in);
    check({ring_dc_offset_out, ring_wave_select_out}, 2'b00);
    // Period word is 16 bits in two independent lanes
    wb(1'b1, 8'h90, 4'h3, 32'h1234ABCD);
    wb(1'b1, 8'h90, 4'h1, 32'h000000FF);
    rd_chk(8'h90, 32'h0000ABFF);
    // Routing codes, status while running, stop on clearing run
    for (int i = 0; i < 2; i++) begin
      for (int r = 0; r < 4; r++) begin
        wb(1'b1, ctl[i], 4'h1, 32'h4 | r);
        repeat (4) @(posedge mclk_in);
        check({tone1_tx_out, tone1_rx_out, tone2_tx_out, tone2_rx_out},
              (i == 0) ? {r[0], r[1], 2'b00} : {2'b00, r[0], r[1]});
        rd_chk(ctl[i], 32'h84 | r);
      end
      wb(1'b1, ctl[i], 4'h1, 32'h0);
      repeat (4) @(posedge mclk_in);
      check({tone1_tx_out, tone1_rx_out, tone2_tx_out, tone2_rx_out}, 4'h0);
    end
    // Zero-cross stop, plain stop, disabled timer; on period of 2 counts
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, 8'(8'h90 + 8 * i), 4'h3, 32'h2);
      wb(1'b1, ctl[i], 4'h1, 32'h35);
      wait_lvl(i, 1'b1, 10);
      repeat (40) @(posedge mclk_in);
      check(tone_on(i), 1'b1);
      zero_cross_in[i] <= 1'b1;
      @(posedge mclk_in);
      zero_cross_in[i] <= 1'b0;
      wait_lvl(i, 1'b0, 5);
      wb(1'b1, ctl[i], 4'h1, 32'h0);
      wb(1'b1, ctl[i], 4'h1, 32'h15);
      wait_lvl(i, 1'b1, 10);
      wait_lvl(i, 1'b0, 40);
      check(n >= TK && n <= 2 * TK + 2, 1'b1);
      wb(1'b1, ctl[i], 4'h1, 32'h0);
      wb(1'b1, ctl[i], 4'h1, 32'h05);
      wait_lvl(i, 1'b1, 10);
      repeat (60) @(posedge mclk_in);
      check(tone_on(i), 1'b1);
      wb(1'b1, ctl[i], 4'h1, 32'h0);
      wb(1'b1, 8'(8'h94 + 8 * i), 4'h3, 32'h3);
    end
    // Cadence repeats with reload on tone one and always on tone two
    for (int i = 0; i < 2; i++) begin
      wb(1'b1, ctl[i], 4'h1, (i == 0) ? 32'h5D : 32'h1D);
      wait_lvl(i, 1'b1, 10);
      wait_lvl(i, 1'b0, 40);
      wait_lvl(i, 1'b1, 40);
      check(n >= 2 * TK && n <= 3 * TK + 2, 1'b1);
      wb(1'b1, ctl[i], 4'h1, 32'h0);
    end
    // Without reload tone one stops after its inactive period
    wb(1'b1, ctl[0], 4'h1, 32'h1D);
    wait_lvl(0, 1'b1, 10);
    wait_lvl(0, 1'b0, 40);
    repeat (60) @(posedge mclk_in);
    check(tone1_tx_out, 1'b0);
    rd_chk(ctl[0], 32'h1D);
    wb(1'b1, ctl[0], 4'h1, 32'h0);
    // Ringing: status, line flag held until dc crossing, running flag
    wb(1'b1, 8'hA0, 4'h3, 32'd20);
    wb(1'b1, 8'hA4, 4'h3, 32'd200);
    wb(1'b1, ctl[2], 4'h1, 32'h1B);
    ring_mode_in <= 1'b1;
    poll_ring(7, 1'b1);
    check(q, 32'h9F);
    check(ring_drive_out, 1'b0);
    ring_dc_cross_in <= 1'b1;
    @(posedge mclk_in);
    ring_dc_cross_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check(ring_drive_out, 1'b1);
    poll_ring(7, 1'b0);
    check(q[5], 1'b1);
    ring_dc_cross_in <= 1'b1;
    @(posedge mclk_in);
    ring_dc_cross_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    check(ring_drive_out, 1'b0);
    ring_mode_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rd_chk(ctl[2], 32'h1B);
    wrap_up();
  end
endmodule // test_tone_ring_osc_control
